// [src/sdram_cmd_pkg.sv]
package sdram_cmd_pkg;
    localparam int NUM_BANKS      = 4;
    localparam int BANK_W         = 2;
    localparam int ADDR_W         = 13;
    localparam int ALL_BANKS_BIT  = 10;
    localparam int CLK_PERIOD_PS  = 10000;
    localparam int TRP_NS         = 15;
    localparam int TRPA_NS        = 15;
    localparam int TRP_CYC        = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TRPA_CYC       = (TRPA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DLL_RELOCK_CYC = 200;
    localparam int CKE_MIN_REG    = 4;
    localparam int TXSNR_NS       = 200;
    localparam int TXSNR_CYC      = (TXSNR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REFRESH_DIV    = 780;
    localparam int CNT_W          = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [2:0] CMD_NOP       = 3'h7;
    localparam logic [2:0] CMD_ACTIVE    = 3'h3;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    typedef enum logic [1:0] {ST_NORMAL, ST_SELF_REFRESH, ST_EXIT_WAIT} sr_state_t;
endpackage

// [src/bank_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module bank_timer
#(
    parameter int W = 16
)
(
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_ce,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output var  logic         o_busy
);
    logic [W-1:0] count;
    wire          done = (count == '0);
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            count <= '0;
        else if (i_ce && i_load)
            count <= i_count;
        else if (i_ce && !done)
            count <= count - 1'b1;
    end
    assign o_busy = !done;
endmodule
`default_nettype wire

// [src/precharge_self_refresh.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - A10 selects single or all-bank precharge
// - Bank address picks bank; ignored for all
// - Self refresh keeps data, no clock
// - Self refresh is REFRESH with CKE low
// - DLL off in self refresh, on after
// - Only CKE matters during self refresh
// - Repeat precharge restarts precharge period
module precharge_self_refresh
#(
    parameter int NB = sdram_cmd_pkg::NUM_BANKS
)
(
    input  wire logic                               i_clk,
    input  wire logic                               i_rst_b,
    input  wire logic                               i_ce,
    input  wire logic                               i_cke,
    input  wire logic                               i_cs_b,
    input  wire logic                               i_ras_b,
    input  wire logic                               i_cas_b,
    input  wire logic                               i_we_b,
    input  wire logic [sdram_cmd_pkg::BANK_W-1:0]   i_bank,
    input  wire logic [sdram_cmd_pkg::ADDR_W-1:0]   i_addr,
    output var  logic [NB-1:0]                      o_bank_open,
    output var  logic [NB-1:0]                      o_bank_precharging,
    output var  logic                               o_self_refresh,
    output var  logic                               o_dll_enabled,
    output var  logic                               o_refresh_tick,
    output var  logic                               o_read_allowed,
    output var  logic                               o_cmd_allowed,
    output var  logic                               o_protocol_error
);
    import sdram_cmd_pkg::*;

    logic                 rst_meta;
    logic                 rst_sync;
    logic                 cke_prev;
    sr_state_t            state;
    sr_state_t            next_state;
    logic [CNT_W-1:0]     dll_cnt;
    logic [CNT_W-1:0]     xsnr_cnt;
    logic [CNT_W-1:0]     ref_cnt;
    logic [2:0]           cke_high_cnt;
    logic [NB-1:0]        busy;
    logic [NB-1:0]        load;
    logic [NB-1:0]        open_q;
    logic [NB-1:0]        next_open;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    wire [2:0] cmd          = {i_ras_b, i_cas_b, i_we_b};
    wire       selected     = !i_cs_b;
    wire       in_sr        = (state == ST_SELF_REFRESH);
    wire       live         = i_cke && cke_prev && !in_sr;
    wire       is_pre       = live && selected && (cmd == CMD_PRECHARGE);
    wire       pre_all      = i_addr[ALL_BANKS_BIT];
    wire       is_act       = live && selected && (cmd == CMD_ACTIVE);
    wire       is_rd        = live && selected && (cmd == CMD_READ);
    wire       is_wr        = live && selected && (cmd == CMD_WRITE);
    wire       sr_entry     = !in_sr && cke_prev && !i_cke && selected
                              && (cmd == CMD_REFRESH);
    wire       sr_exit      = in_sr && i_cke;
    wire       exit_cmd     = (state == ST_EXIT_WAIT) && selected && (cmd != CMD_NOP);
    wire       dll_ok       = (dll_cnt == CNT_ZERO);
    wire       xsnr_ok      = (xsnr_cnt == CNT_ZERO);
    wire       cke_short    = (state == ST_EXIT_WAIT) && !i_cke
                              && (cke_high_cnt < 3'(CKE_MIN_REG));
    wire       bad_rw       = (is_rd || is_wr) && !open_q[i_bank];
    wire       bad_act      = is_act && busy[i_bank];
    wire       bad_read     = is_rd && !dll_ok;
    wire       ref_wrap     = (ref_cnt == CNT_W'(REFRESH_DIV - 1));
    wire       next_error   = bad_rw || bad_act || bad_read || cke_short
                              || (exit_cmd && !xsnr_ok);

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_NORMAL:       if (sr_entry) next_state = ST_SELF_REFRESH;
            ST_SELF_REFRESH: if (sr_exit) next_state = ST_EXIT_WAIT;
            ST_EXIT_WAIT:    if (xsnr_ok && dll_ok) next_state = ST_NORMAL;
        endcase
    end

    genvar b;
    generate
        for (b = 0; b < NB; b++)
        begin : g_bank
            assign load[b] = is_pre && (pre_all || i_bank == BANK_W'(b));
            assign next_open[b] = load[b] ? 1'b0
                                : (is_act && i_bank == BANK_W'(b) && !busy[b]) ? 1'b1
                                : open_q[b];
            bank_timer #(.W(CNT_W)) u_timer
            (
                .i_clk   (i_clk),
                .i_rst_b (rst_sync),
                .i_ce    (i_ce),
                .i_load  (load[b]),
                .i_count (pre_all ? CNT_W'(TRPA_CYC) : CNT_W'(TRP_CYC)),
                .o_busy  (busy[b])
            );
            always_ff @(posedge i_clk or negedge rst_sync)
            begin
                if (!rst_sync)
                    open_q[b] <= 1'b0;
                else if (i_ce && load[b])
                    open_q[b] <= 1'b0;
                else if (i_ce && is_act && i_bank == BANK_W'(b) && !busy[b])
                    open_q[b] <= 1'b1;
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            state        <= ST_NORMAL;
            cke_prev     <= 1'b0;
            dll_cnt      <= CNT_ZERO;
            xsnr_cnt     <= CNT_ZERO;
            cke_high_cnt <= 3'h0;
            ref_cnt      <= CNT_ZERO;
        end
        else if (i_ce)
        begin
            state    <= next_state;
            cke_prev <= i_cke;
            if (sr_exit)
            begin
                dll_cnt      <= CNT_W'(DLL_RELOCK_CYC);
                xsnr_cnt     <= CNT_W'(TXSNR_CYC);
                cke_high_cnt <= 3'h1;
            end
            else
            begin
                if (!dll_ok) dll_cnt <= dll_cnt - 1'b1;
                if (!xsnr_ok) xsnr_cnt <= xsnr_cnt - 1'b1;
                if (i_cke && cke_high_cnt != 3'h7) cke_high_cnt <= cke_high_cnt + 3'h1;
            end
            ref_cnt <= (in_sr && !ref_wrap) ? ref_cnt + 1'b1 : CNT_ZERO;
        end
    end

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            o_bank_open        <= '0;
            o_bank_precharging <= '0;
            o_self_refresh     <= 1'b0;
            o_dll_enabled      <= 1'b1;
            o_refresh_tick     <= 1'b0;
            o_read_allowed     <= 1'b1;
            o_cmd_allowed      <= 1'b1;
            o_protocol_error   <= 1'b0;
        end
        else if (i_ce)
        begin
            o_bank_open        <= next_open;
            o_bank_precharging <= busy;
            o_self_refresh     <= (next_state == ST_SELF_REFRESH);
            o_dll_enabled      <= (next_state != ST_SELF_REFRESH);
            o_refresh_tick     <= in_sr && ref_wrap;
            o_read_allowed     <= dll_ok && (next_state != ST_SELF_REFRESH);
            o_cmd_allowed      <= (next_state == ST_NORMAL);
            o_protocol_error   <= next_error;
        end
    end
endmodule
`default_nettype wire

// [verif/psr_props.sv]
`timescale 1ns/1ps
`default_nettype none
module psr_props
    import sdram_cmd_pkg::*;
#(parameter int NB = 4)
(
    input wire logic          i_clk, i_rst_b, i_ce, i_cke, i_cs_b, i_ras_b, i_cas_b, i_we_b,
    input wire logic [1:0]    i_bank,
    input wire logic [12:0]   i_addr,
    input wire logic [NB-1:0] o_bank_open, o_bank_precharging,
    input wire logic          o_self_refresh, o_dll_enabled, o_refresh_tick,
    input wire logic          o_read_allowed, o_cmd_allowed, o_protocol_error
);
    wire [2:0] c = {i_ras_b, i_cas_b, i_we_b};
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_cmd(k);
        i_ce && !i_cs_b && $past(i_cke) && o_cmd_allowed && c == k;
    endsequence
    sequence s_pre(a);
        s_cmd(CMD_PRECHARGE) ##0 i_cke && i_addr[ALL_BANKS_BIT] == a;
    endsequence
    a_sr_entry: assert property (
        s_cmd(CMD_REFRESH) ##0 !i_cke |=> o_self_refresh && !o_dll_enabled) else $error("no entry");
    a_dll_off: assert property (
        o_self_refresh |-> !o_dll_enabled && !o_cmd_allowed) else $error("dll on in sr");
    a_sr_exit: assert property (
        o_self_refresh && i_cke |=> !o_self_refresh && o_dll_enabled) else $error("no exit");
    a_sr_ignore: assert property (
        o_self_refresh && !i_cke |=> $stable(o_bank_open) && !o_protocol_error) else $error("sr");
    a_read_wait: assert property (
        $fell(o_self_refresh) |-> ##195 !o_read_allowed ##[1:15] o_read_allowed) else $error("rd");
    a_cmd_wait: assert property (
        $fell(o_self_refresh) |-> ##195 !o_cmd_allowed ##[1:15] o_cmd_allowed) else $error("cmd");
    a_tick_in_sr: assert property (
        $rose(o_self_refresh) |-> ##[1:782] (o_refresh_tick || !o_self_refresh)) else $error("tick");
    a_pre_one: assert property (
        s_pre(1'h0) |=> !o_bank_open[$past(i_bank)] ##1 o_bank_precharging[$past(i_bank, 2)])
        else $error("single precharge");
    a_pre_all: assert property (
        s_pre(1'h1) |=> o_bank_open == '0 ##1 o_bank_precharging == '1) else $error("all precharge");
    a_act_busy: assert property (
        s_cmd(CMD_ACTIVE) ##0 i_cke ##1 o_bank_precharging[$past(i_bank)] |-> o_protocol_error)
        else $error("activate during precharge");
endmodule
bind precharge_self_refresh psr_props #(.NB(NB)) u_props (.i_clk, .i_rst_b, .i_ce, .i_cke,
    .i_cs_b, .i_ras_b, .i_cas_b, .i_we_b, .i_bank, .i_addr, .o_bank_open, .o_bank_precharging,
    .o_self_refresh, .o_dll_enabled, .o_refresh_tick, .o_read_allowed, .o_cmd_allowed,
    .o_protocol_error);
`default_nettype wire

// [verif/ddr2_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctrl_model
    import sdram_cmd_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_cke,
    input  wire logic [2:0]  i_cmd,
    input  wire logic [1:0]  i_bank,
    input  wire logic [12:0] i_addr,
    output var  logic        o_cke,
    output var  logic        o_cs_b,
    output var  logic [2:0]  o_cmd,
    output var  logic [1:0]  o_bank,
    output var  logic [12:0] o_addr
);
    int hold = 0;
    logic        c_cke;
    logic [2:0]  c_cmd;
    logic [1:0]  c_bank;
    logic [12:0] c_addr;
    initial {o_cke, o_cs_b, o_cmd, o_bank, o_addr} = {1'h0, 1'h1, CMD_NOP, 2'h0, 13'h0000};
    // Clock runs free, so it is stable around entry and exit
    always @(posedge i_clk)
    begin
        {c_cke, c_cmd, c_bank, c_addr} = {i_cke, i_cmd, i_bank, i_addr};
        #1;
        hold = (c_cke && !o_cke) ? 200 : (hold > 0) ? hold - 1 : 0;
        o_cke = c_cke || hold > 0;
        o_cs_b = 1'h0;
        o_cmd = (hold > 0) ? CMD_NOP : c_cmd;
        o_bank = c_bank;
        o_addr = c_addr;
    end
endmodule
`default_nettype wire

// [verif/precharge_self_refresh_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module precharge_self_refresh_tb;
    import sdram_cmd_pkg::*;
    typedef struct {int due; logic [5:0] v;} note_t;
    logic        clk = 1'h0, rst_b = 1'h0, r_cke = 1'h0, exp_sr = 1'h0, cke, cs_b, err, sr;
    logic [2:0]  r_cmd = CMD_NOP, pins;
    logic [1:0]  r_bank = 2'h0, bank;
    logic [12:0] r_addr = 13'h0000, addr;
    logic [3:0]  open, exp_open = 4'h0;
    note_t       q[$];
    int          cyc = 0, miscompares = 0, samples_checked = 0;
    ddr2_ctrl_model partner (.i_clk(clk), .i_cke(r_cke), .i_cmd(r_cmd), .i_bank(r_bank),
        .i_addr(r_addr), .o_cke(cke), .o_cs_b(cs_b), .o_cmd(pins), .o_bank(bank), .o_addr(addr));
    precharge_self_refresh dut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(1'h1), .i_cke(cke),
        .i_cs_b(cs_b), .i_ras_b(pins[2]), .i_cas_b(pins[1]), .i_we_b(pins[0]), .i_bank(bank),
        .i_addr(addr), .o_bank_open(open), .o_bank_precharging(), .o_self_refresh(sr),
        .o_dll_enabled(), .o_refresh_tick(), .o_read_allowed(), .o_cmd_allowed(),
        .o_protocol_error(err));
    initial forever #5 clk = ~clk;
    always @(posedge clk) cyc++;
    task automatic check(input logic [5:0] seen, input logic [5:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            miscompares++;
            $display("[FAIL] %0t outputs %b expected %b", $time, seen, want);
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic k, input logic e);
        note_t n;
        {r_cmd, r_bank, r_addr, r_cke} = {c, b, a, k};
        if (exp_sr)
            exp_sr = !k;
        else if (c == CMD_REFRESH && !k)
            exp_sr = 1'h1;
        else if (c == CMD_ACTIVE && !e)
            exp_open[b] = 1'h1;
        else if (c == CMD_PRECHARGE)
            exp_open = a[ALL_BANKS_BIT] ? 4'h0 : exp_open & ~(4'h1 << b);
        n.due = cyc + 2;
        n.v = {e, exp_sr, exp_open};
        q.push_back(n);
        @(posedge clk);
        #1;
    endtask
    always @(negedge clk)
        while (q.size() > 0 && q[0].due == cyc)
        begin
            check({err, sr, open}, q[0].v);
            void'(q.pop_front());
        end
    initial
    begin
        #100000;
        miscompares++;
        final_report();
    end
    initial
    begin
        void'($urandom(50));
        repeat (12) @(posedge clk);
        #1 rst_b = 1'h1;
        repeat (210) cmd(CMD_NOP, 2'h0, 13'h0000, 1'h1, 1'h0);
        for (int i = 0; i < 4; i++) cmd(CMD_ACTIVE, 2'(i), 13'($urandom), 1'h1, 1'h0);
        cmd(CMD_PRECHARGE, 2'h1, 13'($urandom) & 13'h1bff, 1'h1, 1'h0);
        cmd(CMD_ACTIVE, 2'h1, 13'h0000, 1'h1, 1'h1);
        cmd(CMD_PRECHARGE, 2'h1, 13'h0000, 1'h1, 1'h0);
        cmd(CMD_ACTIVE, 2'h1, 13'h0000, 1'h1, 1'h1);
        repeat (2) cmd(CMD_NOP, 2'h0, 13'h0000, 1'h1, 1'h0);
        cmd(CMD_ACTIVE, 2'h1, 13'h0000, 1'h1, 1'h0);
        cmd(CMD_PRECHARGE, 2'($urandom), 13'h0400, 1'h1, 1'h0);
        cmd(CMD_ACTIVE, 2'h3, 13'h0000, 1'h1, 1'h1);
        cmd(CMD_READ, 2'h0, 13'h0000, 1'h1, 1'h1);
        repeat (2) cmd(CMD_NOP, 2'h0, 13'h0000, 1'h1, 1'h0);
        cmd(CMD_REFRESH, 2'h0, 13'h0000, 1'h0, 1'h0);
        repeat (800) cmd(3'($urandom), 2'($urandom), 13'($urandom), 1'h0, 1'h0);
        repeat (211) cmd(CMD_NOP, 2'h0, 13'h0000, 1'h1, 1'h0);
        cmd(CMD_ACTIVE, 2'h2, 13'($urandom), 1'h1, 1'h0);
        cmd(CMD_READ, 2'h2, 13'h0000, 1'h1, 1'h0);
        repeat (3) @(posedge clk);
        final_report();
    end
endmodule
`default_nettype wire
